// >>> src/rbss_defs.svh
// constants for the rom bank select steering block
`ifndef RBSS_DEFS_SVH
`define RBSS_DEFS_SVH

// nibble and address widths of the processor data path
`define RBSS_NIB_W      4
`define RBSS_ADDR_W     8

// field positions inside the data written to the port
`define RBSS_BANK_BIT   0
`define RBSS_CODE_HI    3
`define RBSS_CODE_LO    1

// field positions inside the sent register address
`define RBSS_CHIP_HI    7
`define RBSS_CHIP_LO    6
`define RBSS_CHIP_W     2

// chip number that owns the bank select port
`define RBSS_CHIP_SEL   2'h0

// reset values
`define RBSS_PORT_RST   4'h0
`define RBSS_BANK_RST   1'h0
`define RBSS_ADDR_RST   1'h0

`endif

// >>> src/rbss_pkg.sv
// types shared by the rom bank select steering block
`include "rbss_defs.svh"

package rbss_pkg;

  typedef enum logic [0:0] {
    RBSS_BANK0 = 1'b0,
    RBSS_BANK1 = 1'b1
  } rbss_bank_t;

  // state of the port side: stored port value and address match
  typedef struct packed {
    logic [`RBSS_NIB_W-1:0] port;
    logic                   addr_ok;
  } rbss_top_st_t;

  // state of the steering stage: one select line per bank
  typedef struct packed {
    logic sel1;
    logic sel0;
  } rbss_steer_st_t;

endpackage

// >>> src/rbss_steer.sv
// output stage that steers the rom command line to one of two banks
`timescale 1ns/1ps
`default_nettype none

module rbss_steer (
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // command line and the bank that applies to it
  input  wire logic             cmd,
  input  wire rbss_pkg::rbss_bank_t bank,
  // per bank select lines
  output logic                  sel0,
  output logic                  sel1
);
  import rbss_pkg::*;

  rbss_steer_st_t st_q;
  rbss_steer_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.sel1 = cmd & (bank == RBSS_BANK1);
      st_d.sel0 = cmd & (bank == RBSS_BANK0);
    end
  end

  // registered so neither line can glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sel0 = st_q.sel0;
  assign sel1 = st_q.sel1;

endmodule

`default_nettype wire

// >>> src/rbss_top.sv
// rom bank select steering: port latch, address decode and bank steering
`timescale 1ns/1ps
`default_nettype none

`include "rbss_defs.svh"

module rbss_top #(
  parameter int PORT_W = `RBSS_NIB_W
) (
  // clock, reset, enable
  input  wire logic                    REF_CLK,
  input  wire logic                    SYS_RST,
  input  wire logic                    CLK_EN,
  // ram group select and address send
  input  wire logic                    RAM_CMD_SEL,
  input  wire logic                    ADDR_SEND_STB,
  input  wire logic [`RBSS_ADDR_W-1:0] ADDR_SEND_DATA,
  // port write from the processor
  input  wire logic                    PORT_WRITE_STB,
  input  wire logic [PORT_W-1:0]       PORT_WRITE_DATA,
  // rom command line from the processor
  input  wire logic                    ROM_CMD_SEL,
  // steered command lines to the rom banks
  output logic                         ROM_CMD_SEL_BANK0,
  output logic                         ROM_CMD_SEL_BANK1,
  // port lines and current bank
  output logic [PORT_W-1:0]            PORT_OUT,
  output var rbss_pkg::rbss_bank_t     BANK_SEL
);
  import rbss_pkg::*;

  if (PORT_W != `RBSS_NIB_W) begin : g_bad_width
    $error("port width must match the processor nibble");
  end

  function automatic logic chip_hit(input logic [`RBSS_ADDR_W-1:0] a);
    chip_hit = (a[`RBSS_CHIP_HI:`RBSS_CHIP_LO] == `RBSS_CHIP_SEL);
  endfunction

  function automatic rbss_bank_t bank_of(input logic [PORT_W-1:0] v);
    bank_of = rbss_bank_t'(v[`RBSS_BANK_BIT]);
  endfunction

  rbss_top_st_t st_q;
  rbss_top_st_t st_d;
  logic         wr_acc;
  rbss_bank_t   bank_nxt;

  // only writes while ram group 0 is selected count
  assign wr_acc = PORT_WRITE_STB & st_q.addr_ok & RAM_CMD_SEL;

  always_comb begin
    st_d = st_q;
    if (CLK_EN) begin
      // an address sent to another group deselects the port
      if (ADDR_SEND_STB) begin
        st_d.addr_ok = RAM_CMD_SEL & chip_hit(ADDR_SEND_DATA);
      end
      // port value changes on an accepted write only
      if (wr_acc) begin
        st_d.port = PORT_WRITE_DATA;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st_q.port    <= `RBSS_PORT_RST;
      st_q.addr_ok <= `RBSS_ADDR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // bank follows the low port bit
  assign bank_nxt = bank_of(st_d.port);

  // next value steers, so a fetch in the same cycle as the write sees the new bank
  rbss_steer u_steer (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .ce   (CLK_EN),
    .cmd  (ROM_CMD_SEL),
    .bank (bank_nxt),
    .sel0 (ROM_CMD_SEL_BANK0),
    .sel1 (ROM_CMD_SEL_BANK1)
  );

  // upper lines carry the branch code unchanged
  assign PORT_OUT = st_q.port;
  assign BANK_SEL = bank_of(st_q.port);

  property p_bank1_route;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && ROM_CMD_SEL && !wr_acc && BANK_SEL == RBSS_BANK1)
      |=> (ROM_CMD_SEL_BANK1 && !ROM_CMD_SEL_BANK0);
  endproperty
  a_bank1_route: assert property (p_bank1_route)
    else $error("command not routed to bank 1");

  property p_bank0_route;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && ROM_CMD_SEL && !wr_acc && BANK_SEL == RBSS_BANK0)
      |=> (ROM_CMD_SEL_BANK0 && !ROM_CMD_SEL_BANK1);
  endproperty
  a_bank0_route: assert property (p_bank0_route)
    else $error("command not routed to bank 0");

  property p_reset_bank0;
    @(posedge REF_CLK)
      SYS_RST |=> (BANK_SEL == RBSS_BANK0 && PORT_OUT == '0
                   && !ROM_CMD_SEL_BANK0 && !ROM_CMD_SEL_BANK1);
  endproperty
  a_reset_bank0: assert property (p_reset_bank0)
    else $error("reset did not select bank 0");

  property p_one_line;
    @(posedge REF_CLK) disable iff (SYS_RST)
      CLK_EN |=> ((ROM_CMD_SEL_BANK0 || ROM_CMD_SEL_BANK1)
                  == $past(ROM_CMD_SEL));
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("command line lost or duplicated");

  property p_new_bank1;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc && PORT_WRITE_DATA[`RBSS_BANK_BIT])
      ##1 (CLK_EN && ROM_CMD_SEL && !wr_acc)
      |=> ROM_CMD_SEL_BANK1;
  endproperty
  a_new_bank1: assert property (p_new_bank1)
    else $error("fetch after switch not from bank 1");

  property p_hold;
    @(posedge REF_CLK) disable iff (SYS_RST)
      !(CLK_EN && wr_acc) |=> $stable(PORT_OUT) && $stable(BANK_SEL);
  endproperty
  a_hold: assert property (p_hold)
    else $error("selection changed without a port write");

  property p_new_bank0;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc && !PORT_WRITE_DATA[`RBSS_BANK_BIT])
      |=> (BANK_SEL == RBSS_BANK0) ##1
          (!ROM_CMD_SEL_BANK1 || !$past(CLK_EN) || $past(wr_acc));
  endproperty
  a_new_bank0: assert property (p_new_bank0)
    else $error("switch back did not reach bank 0");

  property p_no_overlap;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $changed(BANK_SEL) |-> ($past(CLK_EN && wr_acc) || $past(SYS_RST))
                             && !(ROM_CMD_SEL_BANK0 && ROM_CMD_SEL_BANK1);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("bank changed without write or lines overlap");

  property p_never_both;
    @(posedge REF_CLK) disable iff (SYS_RST)
      !(ROM_CMD_SEL_BANK0 && ROM_CMD_SEL_BANK1);
  endproperty
  a_never_both: assert property (p_never_both)
    else $error("both bank lines active");

  property p_cmd_low;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && !ROM_CMD_SEL)
      |=> (!ROM_CMD_SEL_BANK0 && !ROM_CMD_SEL_BANK1);
  endproperty
  a_cmd_low: assert property (p_cmd_low)
    else $error("bank line active without command");

  property p_idle_bank0;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && !wr_acc && BANK_SEL == RBSS_BANK0)
      |=> !ROM_CMD_SEL_BANK1;
  endproperty
  a_idle_bank0: assert property (p_idle_bank0)
    else $error("bank 1 line active while bank 0 selected");

  property p_freeze;
    @(posedge REF_CLK) disable iff (SYS_RST)
      !CLK_EN |=> ($stable(ROM_CMD_SEL_BANK0) && $stable(ROM_CMD_SEL_BANK1)
                   && $stable(PORT_OUT));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while enable low");

  property p_write_lands;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc)
      |=> (PORT_OUT == $past(PORT_WRITE_DATA));
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("accepted write not stored");

  // the port takes a write in the cycle after an address naming it
  property p_addr_accept;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && ADDR_SEND_STB && RAM_CMD_SEL
       && ADDR_SEND_DATA[`RBSS_CHIP_HI:`RBSS_CHIP_LO] == `RBSS_CHIP_SEL)
      ##1 (CLK_EN && PORT_WRITE_STB && RAM_CMD_SEL)
      |=> (PORT_OUT == $past(PORT_WRITE_DATA));
  endproperty
  a_addr_accept: assert property (p_addr_accept)
    else $error("write after matching address not taken");

  property p_addr_refused;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && ADDR_SEND_STB
       && (!RAM_CMD_SEL
           || ADDR_SEND_DATA[`RBSS_CHIP_HI:`RBSS_CHIP_LO] != `RBSS_CHIP_SEL))
      ##1 (CLK_EN && PORT_WRITE_STB)
      |=> $stable(PORT_OUT);
  endproperty
  a_addr_refused: assert property (p_addr_refused)
    else $error("write taken after a refused address");

endmodule

`default_nettype wire

// >>> tb/rbss_rom_model.sv
// rom bank pair that answers the steered command lines
`timescale 1ns/1ps
`default_nettype none

module rbss_rom_model (
  // steered command lines
  input  wire logic sel0,
  input  wire logic sel1,
  // which bank answered the fetch
  output logic      hit,
  output logic      bank,
  output logic      both
);
  assign hit  = sel0 | sel1;
  assign bank = sel1;
  // two answering banks would fight on the data bus
  assign both = sel0 & sel1;
endmodule

`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the rom bank select steering block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rbss_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b1;
  logic        ram = 1'b1;
  logic        astb = 1'b0;
  logic        wstb = 1'b0;
  logic        cmd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  wd = 4'h0;
  logic [3:0]  port;
  logic [3:0]  xp = 4'h0;
  logic        b0, b1, hit, hbank, both;
  logic        ok = 1'b0;
  logic        lc = 1'b0;
  logic [4:0]  nt;
  logic [31:0] rv;
  rbss_bank_t  bsel;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc_n = 0;
  logic [4:0]  q[$];

  always #12.5 clk = ~clk;

  rbss_top rbss_top_i (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(en),
    .RAM_CMD_SEL(ram), .ADDR_SEND_STB(astb), .ADDR_SEND_DATA(addr),
    .PORT_WRITE_STB(wstb), .PORT_WRITE_DATA(wd), .ROM_CMD_SEL(cmd),
    .ROM_CMD_SEL_BANK0(b0), .ROM_CMD_SEL_BANK1(b1), .PORT_OUT(port),
    .BANK_SEL(bsel));
  rbss_rom_model rbss_rom_model_i (.sel0(b0), .sel1(b1), .hit(hit),
    .bank(hbank), .both(both));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t outputs %h expected %h", $time, s, e);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one cycle of stimulus; the model notes what follows the edge
  task automatic cy(input logic s, e, r, as, input logic [7:0] a,
                    input logic ws, input logic [3:0] d, input logic c);
    @(negedge clk);
    {rst, en, ram, astb, addr, wstb, wd, cmd} = {s, e, r, as, a, ws, d, c};
    if (s) begin
      {xp, ok, lc} = 6'h00;
    end else if (e) begin
      if (ws && ok && r)
        xp = d;
      if (as)
        ok = r && a[7:6] == 2'h0;
      lc = c;
    end
    q.push_back({lc, xp});
  endtask

  // port 0, no call pending, fetch with the write and one fetch after it
  task automatic sw(input logic b, input logic [2:0] code);
    cy(0, 1, 1, 1, 8'h00, 0, 4'h0, 1);
    cy(0, 1, 1, 0, 8'h00, 1, {code, b}, 1);
    cy(0, 1, 1, 0, 8'h00, 0, 4'h0, 1);
  endtask

  always @(posedge clk) begin
    #1;
    if (q.size() > 0) begin
      nt = q.pop_front();
      chk({hit, hbank, both, bsel, port},
          {nt[4], nt[4] & nt[0], 1'b0, nt[0], nt[3:0]});
    end
  end

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    void'($urandom(39));
    repeat (3) cy(1, 1, 1, 1, 8'h00, 1, 4'hf, 1);
    cy(0, 1, 1, 0, 8'h00, 0, 4'h0, 1);
    $display("test reset done");
    // branch code travels with bank bit
    sw(1, 3'h5);
    sw(0, 3'h2);
    sw(1, 3'h7);
    $display("test switch done");
    // writes to other chip, ram group off or frozen are ignored
    cy(0, 1, 1, 1, 8'h40, 0, 4'h0, 1);
    cy(0, 1, 1, 0, 8'h00, 1, 4'h0, 1);
    cy(0, 1, 0, 1, 8'h00, 0, 4'h0, 0);
    cy(0, 1, 1, 0, 8'h00, 1, 4'h0, 1);
    cy(0, 1, 1, 1, 8'h00, 0, 4'h0, 1);
    cy(0, 0, 1, 0, 8'h00, 1, 4'h0, 0);
    cy(0, 1, 0, 0, 8'h00, 1, 4'h0, 1);
    $display("test refused done");
    for (int i = 0; i < 300; i++) begin
      rv = $urandom;
      cy(rv[25:20] == 6'h0, rv[2:0] != 3'h0, rv[4:3] != 2'h0, rv[5],
         {rv[7:6] & {2{rv[8]}}, rv[13:8]}, rv[14], rv[18:15], rv[19]);
    end
    $display("test random done");
    @(posedge clk);
    #2;
    summarize();
  end
endmodule

`default_nettype wire
